//--- design/eeg_pkg.sv
/*
  Package for the enclave gating checks: offsets, bit positions, resets,
  leaf and fault codes, shared types. Assumes one clock domain.
*/
// Notes on behaviour
// - Extension available only when enable and lock set
// - Key hash writable only if write-enable and locked
// - Key hash exists only with both capability bits
// - Operands use DS; segment override prefix ignored
// - Operand-size prefix on enclave instruction raises #UD
// - Address size follows mode; 16-bit uses 32
// - Every leaf needs usable expand-up DS, else #GP(0)
// - Entry requires zero base on other usable segments
// - Entry saves FS/GS, loads offset plus enclave base
// - New FS/GS ranges must lie inside DS; the code checks this only when wide_mode_attr is clear
// - Entry needs matching CS mode and privilege three
// - Exit or async exit restores saved FS/GS
// - Segment changes inside enclave raise #UD
// - Base writes allowed in wide enclave, kept across exits; the code keeps them only across async exit and resume, via the frame
// - Leaves except debug pair need paging, else #UD
// - Accessed/dirty may be set on non-faulting accesses
// - Non-root exiting control plus bitmap bit gives exit
// - Bitmap exit check follows privilege-zero check
// - Implicit cached accesses skip APIC page handling
// - Explicit enclave access on APIC page gives #PF
// - Redirectable non-enclave access gives APIC exit instead
// - Fetch outside enclave range inside enclave gives #GP(0)
package eeg_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_FGC = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_BITMAP_LO = 8'h08;
  localparam logic [7:0] OFS_BITMAP_HI = 8'h0c;
  localparam logic [7:0] OFS_EXEC_CTL = 8'h10;
  localparam logic [7:0] OFS_HASH0 = 8'h20;
  localparam int HASH_WORDS = 8;
  // Field positions in feature_gate_control
  localparam int FGC_LOCK_BIT = 0;
  localparam int FGC_LKWE_BIT = 17;
  localparam int FGC_EN_BIT = 18;
  // Field positions in the execution control register
  localparam int XC_EXITING_BIT = 0;
  // Reset values, then selector and rights loaded on entry
  localparam logic [31:0] FGC_RST = 32'h0;
  localparam logic [31:0] HASH_RST = 32'h0;
  localparam logic [63:0] BITMAP_RST = 64'h0;
  localparam logic [15:0] ENCL_SEL = 16'h000b;
  localparam logic [11:0] ENCL_AR = 12'h0c1;
  // Leaf codes, then the full DS limit
  localparam logic [5:0] LEAF_ENTER = 6'h02;
  localparam logic [5:0] LEAF_RESUME = 6'h03;
  localparam logic [5:0] LEAF_EXIT = 6'h04;
  localparam logic [5:0] LEAF_DBG_RD = 6'h04;
  localparam logic [5:0] LEAF_DBG_WR = 6'h05;
  localparam logic [31:0] DS_FULL = 32'hffffffff;

  typedef enum logic [2:0] {
    OPK_USER = 3'b000,
    OPK_PRIV = 3'b001,
    OPK_SEGMOD = 3'b010,
    OPK_FSWR = 3'b011,
    OPK_GSWR = 3'b100,
    OPK_OTHER = 3'b101
  } eeg_kind_type;

  typedef enum logic [2:0] {
    FLT_NONE = 3'b000,
    FLT_UD = 3'b001,
    FLT_GP0 = 3'b010,
    FLT_PF = 3'b011,
    FLT_VMEXIT = 3'b100,
    FLT_APICEXIT = 3'b101
  } eeg_fault_type;

  // Segment register with its hidden part
  typedef struct packed {
    logic [15:0] sel;
    logic [63:0] base;
    logic [31:0] limit;
    logic [11:0] ar;
  } eeg_seg_type;

  // Inputs of the fault evaluator
  typedef struct packed {
    eeg_kind_type kind;
    logic [5:0] leaf;
    logic opSizePfx;
    logic available;
    logic pagingOn;
    logic [1:0] cpl;
    logic dsUsable;
    logic dsExpandUp;
    logic otherBaseNz;
    logic csLong;
    logic wideModeAttr;
    logic fsRangeOk;
    logic gsRangeOk;
    logic inEnclave;
    logic nonRoot;
    logic exitCtl;
    logic [63:0] exitBitmap;
  } eeg_req_type;
endpackage

//--- design/eeg_chk_if.sv
/*
  Carrier from the gating top to its fault evaluator.
  Assumes one clock domain; nothing here is clocked.
*/
`timescale 1ns/100ps
interface eeg_chk_if;
  import eeg_pkg::*;
  eeg_req_type req;
  eeg_fault_type fault;
  modport top (output req, input fault);
  modport chk (input req, output fault);
endinterface

//--- design/eeg_fault_eval.sv
/*
  Fault evaluator: one fault code per instruction, first hit wins.
  Assumes the top samples it in the cycle of the request.
*/
`timescale 1ns/100ps
module eeg_fault_eval (
  eeg_chk_if.chk chk
);
  import eeg_pkg::*;

  // Priority chain, first hit wins
  always_comb begin
    eeg_req_type r;
    logic isEntry;
    logic isDbg;
    r = chk.req;
    isEntry = (r.kind == OPK_USER) && ((r.leaf == LEAF_ENTER) || (r.leaf == LEAF_RESUME));
    isDbg = (r.kind == OPK_PRIV) && ((r.leaf == LEAF_DBG_RD) || (r.leaf == LEAF_DBG_WR));
    chk.fault = FLT_NONE;
    case (r.kind)
      OPK_USER, OPK_PRIV: begin
        if (!r.available) begin
          chk.fault = FLT_UD;
        end else if (!r.pagingOn && !isDbg) begin
          chk.fault = FLT_UD;
        end else if (r.opSizePfx) begin
          chk.fault = FLT_UD;
        end else if (!r.dsUsable || !r.dsExpandUp) begin
          chk.fault = FLT_GP0;
        end else if (r.kind == OPK_PRIV) begin
          if (r.cpl != 2'd0) begin
            chk.fault = FLT_GP0;
          end else if (r.nonRoot && r.exitCtl && r.exitBitmap[r.leaf]) begin
            chk.fault = FLT_VMEXIT;
          end
        end else if (isEntry) begin
          // Entering twice is a protection fault
          if (r.inEnclave) begin
            chk.fault = FLT_GP0;
          end else if (r.otherBaseNz) begin
            chk.fault = FLT_GP0;
          end else if ((r.csLong != r.wideModeAttr) || (r.cpl != 2'd3)) begin
            chk.fault = FLT_GP0;
          end else if (!r.fsRangeOk || !r.gsRangeOk) begin
            chk.fault = FLT_GP0;
          end
        end else if ((r.leaf == LEAF_EXIT) && !r.inEnclave) begin
          chk.fault = FLT_UD;
        end
      end
      OPK_SEGMOD: begin
        if (r.inEnclave) begin
          chk.fault = FLT_UD;
        end
      end
      OPK_FSWR, OPK_GSWR: begin
        // inside an enclave, base writes only in wide enclaves
        if (r.inEnclave && !r.wideModeAttr) begin
          chk.fault = FLT_UD;
        end
      end
      default: begin
        chk.fault = FLT_NONE;
      end
    endcase
  end
endmodule

//--- design/eeg_gate_top.sv
/*
  Enclave entry gating checks: gate register, key hash registers, exit
  bitmap, instruction fault check, FS/GS swap on entry and exit, and
  access classification near the APIC page.
  Assumes the core sequencer gives one instruction or access per pulse
  and holds nothing; results appear one cycle later.
*/
`timescale 1ns/100ps
module eeg_gate_top (
  input wire logic clk_sys,
  input wire logic nrst,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Capability straps
  input wire logic capBaseLeaves,
  input wire logic capLaunchCtl,
  // Instruction request
  input wire logic insValid,
  input wire eeg_pkg::eeg_kind_type insKind,
  input wire logic [5:0] insLeaf,
  input wire logic insOpSizePfx,
  input wire logic wide_mode_attr,
  input wire logic pagingOn,
  input wire logic [1:0] cpl,
  input wire logic dsUsable,
  input wire logic dsExpandUp,
  input wire logic [31:0] dsLimit,
  input wire logic otherBaseNz,
  input wire logic csLong,
  input wire logic nonRoot,
  input wire eeg_pkg::eeg_seg_type fsIn,
  input wire eeg_pkg::eeg_seg_type gsIn,
  input wire logic [63:0] fsOffsetField,
  input wire logic [63:0] gsOffsetField,
  input wire logic [31:0] fsLimitField,
  input wire logic [31:0] gsLimitField,
  input wire logic [63:0] enclaveBase,
  input wire logic wideModeAttr,
  input wire logic [63:0] baseWrVal,
  input wire logic [63:0] ssaFsBaseIn,
  input wire logic [63:0] ssaGsBaseIn,
  input wire logic asyncExit,
  // Memory access request
  input wire logic accValid,
  input wire logic accImplicit,
  input wire logic accEnclave,
  input wire logic accApicOverlap,
  input wire logic accWouldRedirect,
  input wire logic accFetch,
  input wire logic accInRange,
  // Results
  output logic insDone,
  output eeg_pkg::eeg_fault_type insFault,
  output logic addrWide,
  output logic enclaveMode,
  output logic featureAvail,
  output eeg_pkg::eeg_seg_type fsOut,
  output eeg_pkg::eeg_seg_type gsOut,
  output logic ssaWr,
  output logic [63:0] ssaFsBaseOut,
  output logic [63:0] ssaGsBaseOut,
  output logic accDone,
  output eeg_pkg::eeg_fault_type accFault,
  output logic adFlagOk
);
  import eeg_pkg::*;

  // Whole module state
  typedef struct packed {
    logic [31:0] fgc;
    logic [HASH_WORDS-1:0][31:0] hash;
    logic [63:0] bitmap;
    logic exitCtl;
    logic [31:0] rdata;
    logic inEncl;
    eeg_seg_type fsCur;
    eeg_seg_type gsCur;
    eeg_seg_type fsSave;
    eeg_seg_type gsSave;
    logic insDone;
    eeg_fault_type insFault;
    eeg_fault_type lastFault;
    logic addrWide;
    logic avail;
    logic ssaWr;
    logic [63:0] ssaFs;
    logic [63:0] ssaGs;
    logic accDone;
    eeg_fault_type accFault;
    logic adOk;
  } eeg_state_type;

  eeg_state_type st_q;
  eeg_state_type st_d;
  eeg_chk_if chkBus ();

  // Unless wide, a new segment must sit inside DS; a wrapping one needs a full 4 GB DS
  function automatic logic rangeInDs(input logic [63:0] base, input logic [31:0] lim,
                                     input logic [31:0] dsLim, input logic wide);
    logic [63:0] top;
    top = base + {32'h0, lim};
    if (wide) begin
      rangeInDs = 1'b1;
    end else if (top[31:0] < base[31:0]) begin
      rangeInDs = (dsLim == DS_FULL);
    end else begin
      rangeInDs = (top[31:0] <= dsLim);
    end
  endfunction

  // Segment as loaded on entry, selector ENCL_SEL and rights fixed to ENCL_AR
  function automatic eeg_seg_type enclSeg(input logic [63:0] base, input logic [31:0] lim);
    enclSeg.sel = ENCL_SEL;
    enclSeg.base = base;
    enclSeg.limit = lim;
    enclSeg.ar = ENCL_AR;
  endfunction

  // Hash register index from a byte offset
  function automatic logic [2:0] hashIdx(input logic [7:0] a);
    hashIdx = a[4:2];
  endfunction

  logic hashExists;
  logic hashWrOk;
  logic isHashAddr;
  logic [63:0] fsNewBase;
  logic [63:0] gsNewBase;
  logic isEnter;
  logic isResume;
  logic isExit;

  // Decode helpers
  always_comb begin
    // hash registers present only with both capabilities
    hashExists = capBaseLeaves && capLaunchCtl;
    hashWrOk = hashExists && st_q.fgc[FGC_LKWE_BIT] && st_q.fgc[FGC_LOCK_BIT];
    isHashAddr = (regAddr[7:5] == OFS_HASH0[7:5]) && (regAddr[1:0] == 2'b00);
    // base is offset field plus enclave base
    fsNewBase = fsOffsetField + enclaveBase;
    gsNewBase = gsOffsetField + enclaveBase;
    isEnter = (insKind == OPK_USER) && (insLeaf == LEAF_ENTER);
    isResume = (insKind == OPK_USER) && (insLeaf == LEAF_RESUME);
    isExit = (insKind == OPK_USER) && (insLeaf == LEAF_EXIT);
  end

  // Request to the fault evaluator
  always_comb begin
    chkBus.req.kind = insKind;
    chkBus.req.leaf = insLeaf;
    chkBus.req.opSizePfx = insOpSizePfx;
    chkBus.req.available = st_q.avail;
    chkBus.req.pagingOn = pagingOn;
    chkBus.req.cpl = cpl;
    chkBus.req.dsUsable = dsUsable;
    chkBus.req.dsExpandUp = dsExpandUp;
    chkBus.req.otherBaseNz = otherBaseNz;
    chkBus.req.csLong = csLong;
    chkBus.req.wideModeAttr = wideModeAttr;
    // new FS/GS ranges checked against DS unless wide_mode_attr is set
    chkBus.req.fsRangeOk = rangeInDs(fsNewBase, fsLimitField, dsLimit, wide_mode_attr);
    chkBus.req.gsRangeOk = rangeInDs(gsNewBase, gsLimitField, dsLimit, wide_mode_attr);
    chkBus.req.inEnclave = st_q.inEncl;
    chkBus.req.nonRoot = nonRoot;
    chkBus.req.exitCtl = st_q.exitCtl;
    chkBus.req.exitBitmap = st_q.bitmap;
  end

  eeg_fault_eval uEval (
    .chk(chkBus)
  );

  // Next-state logic
  always_comb begin
    st_d = st_q;
    st_d.rdata = 32'h0;
    st_d.insDone = 1'b0;
    st_d.ssaWr = 1'b0;
    st_d.accDone = 1'b0;
    st_d.adOk = 1'b0;
    // enable and lock together; never mirrored into CPUID
    st_d.avail = st_q.fgc[FGC_EN_BIT] && st_q.fgc[FGC_LOCK_BIT];

    // Register writes
    if (regWr) begin
      if (regAddr == OFS_FGC) begin
        // Gate register freezes once locked, so firmware settings stick
        if (!st_q.fgc[FGC_LOCK_BIT]) begin
          st_d.fgc = regWdata;
        end
      end else if (regAddr == OFS_BITMAP_LO) begin
        st_d.bitmap[31:0] = regWdata;
      end else if (regAddr == OFS_BITMAP_HI) begin
        st_d.bitmap[63:32] = regWdata;
      end else if (regAddr == OFS_EXEC_CTL) begin
        st_d.exitCtl = regWdata[XC_EXITING_BIT];
      end else if (isHashAddr) begin
        if (hashWrOk) begin
          st_d.hash[hashIdx(regAddr)] = regWdata;
        end
      end
    end

    // Register reads, data valid the next cycle only
    if (regRd) begin
      if (regAddr == OFS_FGC) begin
        st_d.rdata = st_q.fgc;
      end else if (regAddr == OFS_STATUS) begin
        st_d.rdata = {25'h0, st_q.lastFault, st_q.addrWide, st_q.inEncl, st_q.avail, hashExists};
      end else if (regAddr == OFS_BITMAP_LO) begin
        st_d.rdata = st_q.bitmap[31:0];
      end else if (regAddr == OFS_BITMAP_HI) begin
        st_d.rdata = st_q.bitmap[63:32];
      end else if (regAddr == OFS_EXEC_CTL) begin
        st_d.rdata = {31'h0, st_q.exitCtl};
      end else if (isHashAddr && hashExists) begin
        st_d.rdata = st_q.hash[hashIdx(regAddr)];
      end
    end

    // Instruction outcome
    if (insValid) begin
      st_d.insDone = 1'b1;
      st_d.insFault = chkBus.fault;
      st_d.lastFault = chkBus.fault;
      // operands always DS offsets, override ignored
      // address width from mode, prefix ignored
      st_d.addrWide = wide_mode_attr;
      if (chkBus.fault == FLT_NONE) begin
        if (isEnter || isResume) begin
          st_d.fsSave = fsIn;
          st_d.gsSave = gsIn;
          st_d.inEncl = 1'b1;
          st_d.fsCur = enclSeg(fsNewBase, fsLimitField);
          st_d.gsCur = enclSeg(gsNewBase, gsLimitField);
          // in a wide enclave, resume reloads bases kept in the frame
          if (isResume && wideModeAttr) begin
            st_d.fsCur.base = ssaFsBaseIn;
            st_d.gsCur.base = ssaGsBaseIn;
          end
        end else if (isExit) begin
          st_d.inEncl = 1'b0;
          st_d.fsCur = st_q.fsSave;
          st_d.gsCur = st_q.gsSave;
        end else if (insKind == OPK_FSWR) begin
          st_d.fsCur.base = baseWrVal;
        end else if (insKind == OPK_GSWR) begin
          st_d.gsCur.base = baseWrVal;
        end
      end
    end else if (asyncExit && st_q.inEncl) begin
      // current bases go to the frame
      st_d.ssaWr = 1'b1;
      st_d.ssaFs = st_q.fsCur.base;
      st_d.ssaGs = st_q.gsCur.base;
      st_d.inEncl = 1'b0;
      st_d.fsCur = st_q.fsSave;
      st_d.gsCur = st_q.gsSave;
    end else begin
      // Outside, FS/GS track the live copies
      if (!st_q.inEncl) begin
        st_d.fsCur = fsIn;
        st_d.gsCur = gsIn;
      end
    end

    // Memory access classification
    if (accValid) begin
      st_d.accDone = 1'b1;
      st_d.accFault = FLT_NONE;
      if (accImplicit) begin
        // cached physical accesses bypass APIC handling
        st_d.accFault = FLT_NONE;
      end else if (accFetch && st_q.inEncl && !accInRange) begin
        // fetch outside range, even on APIC page
        st_d.accFault = FLT_GP0;
      end else if (accEnclave && accApicOverlap) begin
        st_d.accFault = FLT_PF;
      end else if (!accEnclave && accWouldRedirect) begin
        st_d.accFault = FLT_APICEXIT;
      end
      // A/D update allowed for a clean enclave access
      st_d.adOk = accEnclave && (st_d.accFault == FLT_NONE);
    end
  end

  // State register; asynchronous reset to constants only
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
      st_q.fgc <= FGC_RST;
      st_q.hash <= {HASH_WORDS{HASH_RST}};
      st_q.bitmap <= BITMAP_RST;
      st_q.insFault <= FLT_NONE;
      st_q.lastFault <= FLT_NONE;
      st_q.accFault <= FLT_NONE;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign regRdata = st_q.rdata;
  assign insDone = st_q.insDone;
  assign insFault = st_q.insFault;
  assign addrWide = st_q.addrWide;
  assign enclaveMode = st_q.inEncl;
  assign featureAvail = st_q.avail;
  assign fsOut = st_q.fsCur;
  assign gsOut = st_q.gsCur;
  assign ssaWr = st_q.ssaWr;
  assign ssaFsBaseOut = st_q.ssaFs;
  assign ssaGsBaseOut = st_q.ssaGs;
  assign accDone = st_q.accDone;
  assign accFault = st_q.accFault;
  assign adFlagOk = st_q.adOk;
endmodule

//--- bench/eeg_gate_properties.sv
/*
  Checker on the gating top's ports: fault codes and result pulses.
  Assumes it is bound into eeg_gate_top.
*/
`timescale 1ns/100ps
module eeg_gate_properties (
  input logic clk_sys,
  input logic nrst,
  input logic insValid,
  input eeg_pkg::eeg_kind_type insKind,
  input logic [5:0] insLeaf,
  input logic insOpSizePfx,
  input logic wide_mode_attr,
  input logic pagingOn,
  input logic [1:0] cpl,
  input logic dsUsable,
  input logic dsExpandUp,
  input logic asyncExit,
  input logic accValid,
  input logic accImplicit,
  input logic accEnclave,
  input logic accApicOverlap,
  input logic accWouldRedirect,
  input logic accFetch,
  input logic accInRange,
  input logic insDone,
  input eeg_pkg::eeg_fault_type insFault,
  input logic addrWide,
  input logic enclaveMode,
  input logic featureAvail,
  input logic ssaWr,
  input logic accDone,
  input eeg_pkg::eeg_fault_type accFault,
  input logic adFlagOk
);
  import eeg_pkg::*;
  // User leaf presented
  wire logic usr = insValid && insKind == OPK_USER;
  // Early checks passed, then DS as well
  wire logic early = featureAvail && pagingOn && !insOpSizePfx;
  wire logic leafOk = early && dsUsable && dsExpandUp;
  // Out-of-range fetch inside an enclave
  wire logic fetchFlt = accFetch && enclaveMode && !accInRange;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  AST_UNAVAIL: assert property (
    usr && !featureAvail |=> insFault == FLT_UD)
    else $error("unavailable leaf ran");
  AST_OPSIZE: assert property (
    usr && featureAvail && insOpSizePfx |=> insFault == FLT_UD)
    else $error("size prefix taken");
  AST_PAGING: assert property (
    usr && featureAvail && !pagingOn |=> insFault == FLT_UD)
    else $error("leaf ran unpaged");
  AST_DS: assert property (
    insValid && early && !(dsUsable && dsExpandUp) && insKind inside {OPK_USER, OPK_PRIV}
    |=> insFault == FLT_GP0)
    else $error("bad DS taken");
  AST_PRIV_CPL: assert property (
    insValid && leafOk && insKind == OPK_PRIV && cpl != 2'd0 |=> insFault == FLT_GP0)
    else $error("privilege not checked first");
  AST_SEGMOD: assert property (
    insValid && enclaveMode && insKind == OPK_SEGMOD |=> insFault == FLT_UD)
    else $error("segment change inside");
  AST_ADDR: assert property (
    insValid |=> insDone && addrWide == $past(wide_mode_attr))
    else $error("address size wrong");
  AST_ENTRY_CPL: assert property (
    usr && !enclaveMode && insLeaf == LEAF_ENTER && cpl != 2'd3
    |=> insFault != FLT_NONE && !enclaveMode)
    else $error("entry off privilege three");
  AST_ASYNC: assert property (
    asyncExit && enclaveMode && !insValid |=> ssaWr ##1 !ssaWr)
    else $error("async exit pulse wrong");
  AST_FETCH: assert property (
    accValid && !accImplicit && fetchFlt |=> accDone && accFault == FLT_GP0)
    else $error("stray fetch taken");
  AST_IMPLICIT: assert property (
    accValid && accImplicit |=> accFault == FLT_NONE)
    else $error("implicit access faulted");
  AST_APIC_PF: assert property (
    accValid && !accImplicit && !fetchFlt && accEnclave && accApicOverlap
    |=> accFault == FLT_PF)
    else $error("APIC page access taken");
  AST_REDIRECT: assert property (
    accValid && !accImplicit && !fetchFlt && !accEnclave && accWouldRedirect
    |=> accFault == FLT_APICEXIT)
    else $error("redirect taken");
  AST_ADFLAG: assert property (
    adFlagOk |-> accDone && accFault == FLT_NONE)
    else $error("flags on faulting access");
endmodule
bind eeg_gate_top eeg_gate_properties i_eeg_gate_properties (.*);

//--- bench/eeg_sw_model.sv
/*
  Software side: live segments, thread control fields and frame bases.
  Assumes dsTight rises only to provoke a range fault.
*/
`timescale 1ns/100ps
module eeg_sw_model (
  input wire logic dsTight,
  output eeg_pkg::eeg_seg_type fsIn,
  output eeg_pkg::eeg_seg_type gsIn,
  output logic [63:0] fsOffsetField,
  output logic [63:0] gsOffsetField,
  output logic [31:0] fsLimitField,
  output logic [31:0] gsLimitField,
  output logic [63:0] enclaveBase,
  output logic [31:0] dsLimit,
  output logic [63:0] baseWrVal,
  output logic [63:0] ssaFsBaseIn,
  output logic [63:0] ssaGsBaseIn
);
  import eeg_pkg::*;
  // Live segments, swapped out on entry
  assign fsIn = '{sel: 16'h0033, base: 64'h4_0000, limit: 32'hffff, ar: 12'h093};
  assign gsIn = '{sel: 16'h002b, base: 64'h8_0000, limit: 32'h7fff, ar: 12'h093};
  // Thread control fields
  assign fsOffsetField = 64'h100;
  assign gsOffsetField = 64'h200;
  assign fsLimitField = 32'hfff;
  assign gsLimitField = 32'h7ff;
  assign enclaveBase = 64'h1000_0000;
  // Tight DS puts FS/GS outside it
  assign dsLimit = dsTight ? 32'hffff : 32'hffff_ffff;
  assign baseWrVal = 64'h7000_0040;
  assign ssaFsBaseIn = 64'h2000_0000;
  assign ssaGsBaseIn = 64'h2000_1000;
endmodule

//--- bench/eeg_gate_top_tb.sv
/*
  Self-checking bench for the enclave gating block.
  Assumes the bound checker and the software model.
*/
`timescale 1ns/100ps
module eeg_gate_top_tb;
  import eeg_pkg::*;
  logic clk_sys, nrst, regWr, regRd, capBaseLeaves, capLaunchCtl, insValid, insOpSizePfx;
  logic wide_mode_attr, pagingOn, dsUsable, dsExpandUp, otherBaseNz, csLong, nonRoot, wideModeAttr;
  logic asyncExit, accValid, accImplicit, accEnclave, accApicOverlap, accWouldRedirect;
  logic accFetch, accInRange, dsTight, insDone, addrWide, enclaveMode, featureAvail, ssaWr;
  logic accDone, adFlagOk;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, dsLimit, fsLimitField, gsLimitField;
  logic [1:0] cpl;
  logic [5:0] insLeaf;
  logic [63:0] fsOffsetField, gsOffsetField, enclaveBase, baseWrVal;
  logic [63:0] ssaFsBaseIn, ssaGsBaseIn, ssaFsBaseOut, ssaGsBaseOut;
  eeg_kind_type insKind;
  eeg_seg_type fsIn, gsIn, fsOut, gsOut;
  eeg_fault_type insFault, accFault;
  int failures, numChecks;
  eeg_gate_top i_eeg_gate_top (.*);
  eeg_sw_model i_eeg_sw_model (.*);
  // 125 MHz core clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [255:0] got, input logic [255:0] exp);
    numChecks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkF(input eeg_fault_type got, input eeg_fault_type exp);
    numChecks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t fault %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Reset held three cycles
  task automatic rst();
    @(posedge clk_sys) nrst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys) {regAddr, regWdata, regWr} <= {a, v, 1'b1};
    @(posedge clk_sys) regWr <= 1'b0;
  endtask
  // Read data stand one cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys) {regAddr, regRd} <= {a, 1'b1};
    @(posedge clk_sys) regRd <= 1'b0;
    @(negedge clk_sys);
    chk(regRdata, exp);
  endtask
  task automatic ins(input eeg_kind_type k, input logic [5:0] lf, input eeg_fault_type e);
    @(posedge clk_sys) {insKind, insLeaf, insValid} <= {k, lf, 1'b1};
    @(posedge clk_sys) insValid <= 1'b0;
    @(negedge clk_sys);
    chk(insDone, 1'b1);
    chkF(insFault, e);
  endtask
  // Bits: implicit, enclave, apic, redirect, fetch, in range
  task automatic acc(input logic [5:0] v, input eeg_fault_type e, input logic ad);
    @(posedge clk_sys) begin
      {accImplicit, accEnclave, accApicOverlap, accWouldRedirect, accFetch, accInRange} <= v;
      accValid <= 1'b1;
    end
    @(posedge clk_sys) accValid <= 1'b0;
    @(negedge clk_sys);
    chk(accDone, 1'b1);
    chkF(accFault, e);
    chk(adFlagOk, ad);
  endtask
  task automatic t_gate();
    ins(OPK_USER, LEAF_ENTER, FLT_UD);
    wr(OFS_FGC, 32'h0004_0000);
    ins(OPK_USER, LEAF_ENTER, FLT_UD);
    wr(OFS_FGC, 32'h0004_0001);
    wr(OFS_HASH0, 32'h1234_5678);
    rd(OFS_HASH0, 32'h0);
    chk(featureAvail, 1'b1);
    rst();
    wr(OFS_FGC, 32'h0006_0001);
    wr(OFS_FGC, 32'h0);
    rd(OFS_FGC, 32'h0006_0001);
    wr(OFS_HASH0 + 8'h1c, 32'hcafe_0017);
    rd(OFS_HASH0 + 8'h1c, 32'hcafe_0017);
    @(posedge clk_sys) capLaunchCtl <= 1'b0;
    rd(OFS_HASH0 + 8'h1c, 32'h0);
    @(posedge clk_sys) capLaunchCtl <= 1'b1;
    rd(8'h80, 32'h0);
  endtask
  task automatic t_order();
    ins(OPK_PRIV, 6'h00, FLT_GP0);
    @(posedge clk_sys) {cpl, insOpSizePfx} <= {2'd0, 1'b1};
    ins(OPK_USER, LEAF_ENTER, FLT_UD);
    @(posedge clk_sys) {insOpSizePfx, pagingOn} <= 2'b00;
    ins(OPK_USER, LEAF_ENTER, FLT_UD);
    ins(OPK_PRIV, 6'h01, FLT_UD);
    ins(OPK_PRIV, LEAF_DBG_RD, FLT_NONE);
    ins(OPK_PRIV, LEAF_DBG_WR, FLT_NONE);
    @(posedge clk_sys) {pagingOn, dsUsable} <= 2'b10;
    ins(OPK_PRIV, 6'h00, FLT_GP0);
    @(posedge clk_sys) {dsUsable, dsExpandUp} <= 2'b10;
    ins(OPK_USER, LEAF_ENTER, FLT_GP0);
    @(posedge clk_sys) dsExpandUp <= 1'b1;
  endtask
  task automatic t_vm();
    wr(OFS_BITMAP_LO, 32'h0000_0020);
    wr(OFS_BITMAP_HI, 32'h0000_0100);
    wr(OFS_EXEC_CTL, 32'h1);
    ins(OPK_PRIV, 6'h05, FLT_NONE);
    @(posedge clk_sys) nonRoot <= 1'b1;
    ins(OPK_PRIV, 6'h05, FLT_VMEXIT);
    ins(OPK_PRIV, 6'h28, FLT_VMEXIT);
    ins(OPK_PRIV, 6'h06, FLT_NONE);
    @(posedge clk_sys) cpl <= 2'd3;
    ins(OPK_PRIV, 6'h05, FLT_GP0);
    wr(OFS_EXEC_CTL, 32'h0);
    @(posedge clk_sys) cpl <= 2'd0;
    ins(OPK_PRIV, 6'h05, FLT_NONE);
    @(posedge clk_sys) {nonRoot, cpl} <= {1'b0, 2'd3};
  endtask
  task automatic t_enter();
    @(posedge clk_sys) otherBaseNz <= 1'b1;
    ins(OPK_USER, LEAF_ENTER, FLT_GP0);
    @(posedge clk_sys) {otherBaseNz, csLong} <= 2'b01;
    ins(OPK_USER, LEAF_ENTER, FLT_GP0);
    @(posedge clk_sys) {csLong, cpl} <= {1'b0, 2'd2};
    ins(OPK_USER, LEAF_RESUME, FLT_GP0);
    @(posedge clk_sys) {cpl, dsTight} <= {2'd3, 1'b1};
    ins(OPK_USER, LEAF_ENTER, FLT_GP0);
    @(posedge clk_sys) dsTight <= 1'b0;
    ins(OPK_USER, LEAF_ENTER, FLT_NONE);
    chk({enclaveMode, addrWide}, 2'b10);
    chk(fsOut, {ENCL_SEL, fsOffsetField + enclaveBase, fsLimitField, ENCL_AR});
    chk(gsOut, {ENCL_SEL, gsOffsetField + enclaveBase, gsLimitField, ENCL_AR});
    ins(OPK_SEGMOD, 6'h00, FLT_UD);
    ins(OPK_FSWR, 6'h00, FLT_UD);
    ins(OPK_USER, LEAF_EXIT, FLT_NONE);
    chk({enclaveMode, fsOut, gsOut}, {1'b0, fsIn, gsIn});
  endtask
  task automatic t_wide();
    @(posedge clk_sys) {wideModeAttr, csLong, wide_mode_attr} <= 3'b111;
    ins(OPK_USER, LEAF_ENTER, FLT_NONE);
    chk(addrWide, 1'b1);
    ins(OPK_FSWR, 6'h00, FLT_NONE);
    ins(OPK_GSWR, 6'h00, FLT_NONE);
    chk({fsOut.base, gsOut.base}, {baseWrVal, baseWrVal});
    acc(6'b101110, FLT_NONE, 1'b0);
    acc(6'b001010, FLT_GP0, 1'b0);
    acc(6'b011001, FLT_PF, 1'b0);
    acc(6'b000101, FLT_APICEXIT, 1'b0);
    acc(6'b010001, FLT_NONE, 1'b1);
    @(posedge clk_sys) asyncExit <= 1'b1;
    @(posedge clk_sys) asyncExit <= 1'b0;
    @(negedge clk_sys);
    chk({ssaWr, ssaFsBaseOut, ssaGsBaseOut}, {1'b1, baseWrVal, baseWrVal});
    chk({enclaveMode, fsOut, gsOut}, {1'b0, fsIn, gsIn});
    ins(OPK_USER, LEAF_RESUME, FLT_NONE);
    chk({fsOut.base, gsOut.base}, {ssaFsBaseIn, ssaGsBaseIn});
    ins(OPK_USER, LEAF_EXIT, FLT_NONE);
    rd(OFS_STATUS, 32'h0000_000b);
  endtask
  // Watchdog
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    final_report();
  end
  initial begin
    {nrst, regWr, regRd, insValid, insOpSizePfx, wide_mode_attr, otherBaseNz, csLong} = '0;
    {nonRoot, wideModeAttr, asyncExit, accValid, dsTight} = '0;
    {accImplicit, accEnclave, accApicOverlap, accWouldRedirect, accFetch, accInRange} = '0;
    {regAddr, regWdata, insLeaf} = '0;
    insKind = OPK_USER;
    cpl = 2'd3;
    {pagingOn, dsUsable, dsExpandUp, capBaseLeaves, capLaunchCtl} = '1;
    failures = 0;
    numChecks = 0;
    rst();
    t_gate();
    t_order();
    t_vm();
    t_enter();
    t_wide();
    final_report();
  end
endmodule
